/* File: design/sct_pkg.sv */
// Package of constants and carrier types for the slow counter with periodic tick
package sct_pkg;

  // ----------------------------------------------------------------
  // Widths, constants and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PRESC_W        = 15;
  localparam int unsigned COUNT_W        = 16;
  localparam int unsigned ACC_W          = 20;
  localparam logic [ACC_W-1:0] MILLION   = 20'hF_4240;
  localparam logic [1:0]  SYNC_CYCLES    = 2'h2;
  localparam logic [3:0]  TICK_OFF       = 4'h0;
  localparam logic [3:0]  TICK_SEL_MAX   = 4'hE;
  localparam int unsigned LEVEL_LOW_BIT  = 5;
  localparam int unsigned LEVEL_COUNT    = 8;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 15'h0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]         timebase_source_select;
    logic               counter_enable_bit;
    logic               tick_enable_bit;
    logic [3:0]         divider_setting;
    logic [3:0]         tick_interval;
    logic               drift_fix_enable;
    logic               drift_sign;
    logic [6:0]         drift_ppm;
    logic [COUNT_W-1:0] wrap_limit;
    logic [COUNT_W-1:0] match_value;
  } sct_cfg_s;

  localparam sct_cfg_s CFG_RESET = '{
    timebase_source_select: 2'h0,
    counter_enable_bit:     1'b0,
    tick_enable_bit:        1'b0,
    divider_setting:        4'h0,
    tick_interval:          4'h0,
    drift_fix_enable:       1'b0,
    drift_sign:             1'b0,
    drift_ppm:              7'h00,
    wrap_limit:             16'hFFFF,
    match_value:            16'h0000
  };

  typedef enum logic [1:0] {
    SCT_FIX_NONE = 2'b00,
    SCT_FIX_SKIP = 2'b01,
    SCT_FIX_HOLD = 2'b10
  } sct_fix_e;

endpackage

/* File: design/sct_slow_counter.sv */
// Slow counter and periodic tick timer sharing one prescaler
module sct_slow_counter
  import sct_pkg::*;
(
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_reset_n,
  input  wire logic [3:0]              i_source_tick,
  input  wire logic                    i_cfg_write,
  input  wire sct_cfg_s                i_cfg,
  input  wire logic                    i_match_irq_enable,
  input  wire logic                    i_wrap_irq_enable,
  input  wire logic                    i_tick_irq_enable,
  input  wire logic                    i_match_flag_clear,
  input  wire logic                    i_wrap_flag_clear,
  input  wire logic                    i_tick_flag_clear,
  output logic                         o_sync_busy,
  output logic [COUNT_W-1:0]           o_count_value,
  output logic                         o_match_flag,
  output logic                         o_wrap_flag,
  output logic                         o_tick_flag,
  output logic                         o_counter_irq,
  output logic                         o_tick_irq,
  output logic                         o_match_event,
  output logic                         o_wrap_event,
  output logic                         o_tick_out,
  output logic [LEVEL_COUNT-1:0]       o_tick_level_event
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when the step crosses a multiple of 2**bits; the top wrap
  // crosses every stage, so a skip by two loses a stage tick only when bits is 0.
  function automatic logic stage_wrapped(input logic [PRESC_W-1:0] old_v,
                                         input logic [PRESC_W-1:0] new_v,
                                         input logic [3:0]         bits);
    return ((new_v >> bits) != (old_v >> bits)) || (new_v < old_v);
  endfunction

  // ----------------------------------------------------------------
  // Configuration transfer
  // ----------------------------------------------------------------
  sct_cfg_s   shadow;
  sct_cfg_s   cfg;
  logic [1:0] sync_count;

  // Writes during busy are ignored; software must poll first
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      shadow     <= CFG_RESET;
      cfg        <= CFG_RESET;
      sync_count <= 2'h0;
    end
    else if (sync_count != 2'h0)
    begin
      sync_count <= sync_count - 2'h1;
      if (sync_count == 2'h1)
        cfg <= shadow;
    end
    else if (i_cfg_write)
    begin
      shadow     <= i_cfg;
      sync_count <= SYNC_CYCLES;
    end
  end

  assign o_sync_busy = (sync_count != 2'h0);

  // ----------------------------------------------------------------
  // Shared prescaler with drift correction
  // ----------------------------------------------------------------
  logic [PRESC_W-1:0] presc;
  logic [PRESC_W-1:0] next_presc;
  logic [ACC_W-1:0]   drift_acc;
  sct_fix_e           fix_pending;
  logic               src_step;
  logic               presc_run;

  assign src_step  = i_source_tick[cfg.timebase_source_select];
  assign presc_run = cfg.counter_enable_bit | cfg.tick_enable_bit;

  always_comb
  begin
    next_presc = presc;
    if (presc_run && src_step)
    begin
      unique case (fix_pending)
        SCT_FIX_SKIP: next_presc = presc + PRESC_W'(2);
        SCT_FIX_HOLD: next_presc = presc;
        SCT_FIX_NONE: next_presc = presc + PRESC_W'(1);
        default:      next_presc = presc + PRESC_W'(1);
      endcase
    end
  end

  // Prescaler keeps its phase when halted, hence the uncertain first tick
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      presc <= PRESC_RESET;
    else
      presc <= next_presc;
  end

  // Correction is spread evenly: one fix every million/ppm input cycles
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      drift_acc   <= '0;
      fix_pending <= SCT_FIX_NONE;
    end
    else if (presc_run && src_step)
    begin
      if (fix_pending != SCT_FIX_NONE)
        fix_pending <= SCT_FIX_NONE;
      else if (cfg.drift_fix_enable)
      begin
        if (drift_acc + ACC_W'(cfg.drift_ppm) >= MILLION)
        begin
          drift_acc   <= drift_acc + ACC_W'(cfg.drift_ppm) - MILLION;
          fix_pending <= cfg.drift_sign ? SCT_FIX_HOLD : SCT_FIX_SKIP;
        end
        else
          drift_acc <= drift_acc + ACC_W'(cfg.drift_ppm);
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter, match and wrap
  // ----------------------------------------------------------------
  logic count_step;

  assign count_step = cfg.counter_enable_bit && stage_wrapped(presc, next_presc, cfg.divider_setting);

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_count_value <= COUNT_RESET;
      o_match_event <= 1'b0;
      o_wrap_event  <= 1'b0;
    end
    else
    begin
      o_match_event <= count_step && (o_count_value == cfg.match_value);
      o_wrap_event  <= count_step && (o_count_value == cfg.wrap_limit);
      if (count_step)
        o_count_value <= (o_count_value == cfg.wrap_limit) ? COUNT_RESET : o_count_value + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Tick output and level events
  // ----------------------------------------------------------------
  logic tick_sel_ok;
  logic next_tick_out;

  assign tick_sel_ok   = cfg.tick_enable_bit && (cfg.tick_interval != TICK_OFF)
                         && (cfg.tick_interval <= TICK_SEL_MAX);
  assign next_tick_out = tick_sel_ok && next_presc[cfg.tick_interval];

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_tick_out         <= 1'b0;
      o_tick_level_event <= '0;
    end
    else
    begin
      o_tick_out         <= next_tick_out;
      o_tick_level_event <= cfg.tick_enable_bit ?
                            next_presc[LEVEL_LOW_BIT +: LEVEL_COUNT] : '0;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags; a set in the clear cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_match_flag <= 1'b0;
      o_wrap_flag  <= 1'b0;
      o_tick_flag  <= 1'b0;
    end
    else
    begin
      o_match_flag <= (count_step && (o_count_value == cfg.match_value)) || (o_match_flag && !i_match_flag_clear);
      o_wrap_flag  <= (count_step && (o_count_value == cfg.wrap_limit)) || (o_wrap_flag && !i_wrap_flag_clear);
      o_tick_flag  <= (next_tick_out && !o_tick_out) || (o_tick_flag && !i_tick_flag_clear);
    end
  end

  assign o_counter_irq = (o_match_flag && i_match_irq_enable) || (o_wrap_flag && i_wrap_irq_enable);
  assign o_tick_irq    = o_tick_flag && i_tick_irq_enable;

endmodule

/* File: verif/sct_slow_counter_monitor.sv */
// Concurrent checks on the ports of the slow counter with periodic tick
module sct_slow_counter_monitor
  import sct_pkg::*;
(
  input wire logic               i_sys_clk,
  input wire logic               i_reset_n,
  input wire logic [3:0]         i_source_tick,
  input wire logic               i_cfg_write,
  input wire logic               i_match_irq_enable,
  input wire logic               i_wrap_irq_enable,
  input wire logic               i_tick_irq_enable,
  input wire logic               o_sync_busy,
  input wire logic [COUNT_W-1:0] o_count_value,
  input wire logic               o_match_flag,
  input wire logic               o_wrap_flag,
  input wire logic               o_tick_flag,
  input wire logic               o_counter_irq,
  input wire logic               o_tick_irq,
  input wire logic               o_match_event,
  input wire logic               o_wrap_event,
  input wire logic               o_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence busy_window;
    o_sync_busy [*2] ##1 !o_sync_busy;
  endsequence
  sequence stepped;
    $past(|i_source_tick);
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_busy_two_cycles: assert property (i_cfg_write && !o_sync_busy |=> busy_window)
    else $error("busy window not two cycles");
  a_wrap_clears_count: assert property (o_wrap_event |-> (o_count_value == '0) and stepped)
    else $error("wrap event without step or zero count");
  a_wrap_sets_flag: assert property (o_wrap_event |-> o_wrap_flag)
    else $error("wrap event without flag");
  a_match_sets_flag: assert property (o_match_event |-> o_match_flag and stepped)
    else $error("match event without flag or step");
  a_counter_irq_mask: assert property (o_counter_irq == ((o_match_flag & i_match_irq_enable)
                                        | (o_wrap_flag & i_wrap_irq_enable)))
    else $error("counter irq not flag and enable");
  a_tick_irq_mask: assert property (o_tick_irq == (o_tick_flag & i_tick_irq_enable))
    else $error("tick irq not flag and enable");
  a_tick_rise_flag: assert property ($rose(o_tick_out) |-> o_tick_flag)
    else $error("tick rise without flag");
  a_count_needs_step: assert property (!$past(|i_source_tick) |-> $stable(o_count_value))
    else $error("count moved without step");
  a_tick_needs_step: assert property ($changed(o_tick_out) |-> stepped or $past(o_sync_busy, 2))
    else $error("tick toggled without step");
endmodule

bind sct_slow_counter sct_slow_counter_monitor u_mon (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
  .i_source_tick(i_source_tick), .i_cfg_write(i_cfg_write), .i_match_irq_enable(i_match_irq_enable),
  .i_wrap_irq_enable(i_wrap_irq_enable), .i_tick_irq_enable(i_tick_irq_enable), .o_sync_busy(o_sync_busy),
  .o_count_value(o_count_value), .o_match_flag(o_match_flag), .o_wrap_flag(o_wrap_flag),
  .o_tick_flag(o_tick_flag), .o_counter_irq(o_counter_irq), .o_tick_irq(o_tick_irq),
  .o_match_event(o_match_event), .o_wrap_event(o_wrap_event), .o_tick_out(o_tick_out));

/* File: verif/sct_slow_counter_test.sv */
// Self-checking bench for the slow counter with periodic tick
module sct_slow_counter_test
  import sct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0]  src;
    logic [15:0] wrap;
    logic [15:0] match;
    logic [3:0]  steps;
    logic [15:0] cnt;
    logic        wf;
    logic        mf;
  } sct_row_s;
  logic i_sys_clk = 0, i_reset_n = 0, cfg_wr = 0, m_clr = 0, w_clr = 0, t_clr = 0;
  logic [3:0] tick_src = '0;
  logic [1:0] src = '0;
  sct_cfg_s cfg = CFG_RESET;
  logic busy, mf, wf, tf, cirq, tirq, mev, wev, tout;
  logic [15:0] cnt;
  logic [7:0] lvl;
  int bad_count = 0, n_compared = 0;
  sct_row_s rows [4] = '{'{2'h0, 16'h0003, 16'h0001, 4'h2, 16'h0002, 1'b0, 1'b1},
                         '{2'h1, 16'h0003, 16'h0005, 4'h4, 16'h0000, 1'b1, 1'b0},
                         '{2'h2, 16'h0000, 16'h0000, 4'h3, 16'h0000, 1'b1, 1'b1},
                         '{2'h3, 16'hFFFF, 16'h0005, 4'h6, 16'h0006, 1'b0, 1'b1}};
  always #5 i_sys_clk = ~i_sys_clk;
  sct_slow_counter u_dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_source_tick(tick_src),
    .i_cfg_write(cfg_wr), .i_cfg(cfg), .i_match_irq_enable(1'b1), .i_wrap_irq_enable(1'b1),
    .i_tick_irq_enable(1'b1), .i_match_flag_clear(m_clr), .i_wrap_flag_clear(w_clr),
    .i_tick_flag_clear(t_clr), .o_sync_busy(busy), .o_count_value(cnt), .o_match_flag(mf),
    .o_wrap_flag(wf), .o_tick_flag(tf), .o_counter_irq(cirq), .o_tick_irq(tirq), .o_match_event(mev),
    .o_wrap_event(wev), .o_tick_out(tout), .o_tick_level_event(lvl));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Unselected sources pulse between steps, so a wrong source pick shows
  task automatic step(input int n);
    repeat (n)
    begin
      @(negedge i_sys_clk) tick_src = 4'h1 << src;
      @(negedge i_sys_clk) tick_src = ~(4'h1 << src);
    end
    @(negedge i_sys_clk) tick_src = '0;
  endtask
  task automatic write_cfg(input sct_cfg_s c);
    @(negedge i_sys_clk);
    while (busy !== 1'b0) @(negedge i_sys_clk);
    cfg = c;
    cfg_wr = 1;
    @(negedge i_sys_clk) cfg_wr = 0;
    chk("busy", 1, busy);
    repeat (2) @(negedge i_sys_clk);
    chk("busy", 0, busy);
  endtask
  task automatic do_reset();
    @(negedge i_sys_clk) i_reset_n = 0;
    repeat (2) @(negedge i_sys_clk);
    i_reset_n = 1;
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #500000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    sct_cfg_s c;
    repeat (16) @(negedge i_sys_clk);
    i_reset_n = 1;
    chk("busy", 0, busy);
    chk("count", 0, cnt);
    foreach (rows[i])
    begin
      do_reset();
      src = rows[i].src;
      c = CFG_RESET;
      c.timebase_source_select = src;
      c.counter_enable_bit = 1;
      c.wrap_limit = rows[i].wrap;
      c.match_value = rows[i].match;
      write_cfg(c);
      step(rows[i].steps);
      chk("count", rows[i].cnt, cnt);
      chk("wrap_flag", rows[i].wf, wf);
      chk("match_flag", rows[i].mf, mf);
      chk("counter_irq", rows[i].wf | rows[i].mf, cirq);
      @(negedge i_sys_clk) w_clr = 1;
      @(negedge i_sys_clk) w_clr = 0;
      chk("wrap_flag", 0, wf);
    end
    c.counter_enable_bit = 0;
    write_cfg(c);
    step(2);
    chk("count", 16'h0006, cnt);
    @(negedge i_sys_clk) m_clr = 1;
    @(negedge i_sys_clk) m_clr = 0;
    chk("match_flag", 0, mf);
    chk("counter_irq", 0, cirq);
    do_reset();
    src = 2'h1;
    c = CFG_RESET;
    c.timebase_source_select = src;
    c.tick_interval = 4'h1;
    write_cfg(c);
    step(3);
    c.tick_enable_bit = 1;
    write_cfg(c);
    step(2);
    chk("tick_out", 1, tout);
    chk("tick_irq", 1, tirq);
    @(negedge i_sys_clk) t_clr = 1;
    @(negedge i_sys_clk) t_clr = 0;
    chk("tick_irq", 0, tirq);
    step(2);
    chk("tick_out", 0, tout);
    step(2);
    chk("tick_out", 1, tout);
    step(26);
    chk("level", 8'h01, lvl);
    c.tick_enable_bit = 0;
    write_cfg(c);
    @(negedge i_sys_clk);
    chk("level", 8'h00, lvl);
    // Skip fix lands one step after the 7875th step arms it
    do_reset();
    src = 2'h2;
    c = CFG_RESET;
    c.timebase_source_select = src;
    c.counter_enable_bit = 1;
    c.divider_setting = 4'h1;
    c.drift_fix_enable = 1;
    c.drift_ppm = 7'h7F;
    write_cfg(c);
    step(7879);
    chk("count", 16'h0F64, cnt);
    do_reset();
    c.drift_sign = 1;
    write_cfg(c);
    step(7880);
    chk("count", 16'h0F63, cnt);
    stop_test();
  end
endmodule
